// >>> dram_ctrl_consts.svh
// Timing and geometry constants for the multiplexed-address DRAM controller
`ifndef DRAM_CTRL_CONSTS_SVH
`define DRAM_CTRL_CONSTS_SVH
`define CLK_PERIOD_PS   4000
`define REF_PERIOD_NS   4000000
`define ROW_COUNT       256
`define T_RAS_MIN_NS    200
`define T_RAS_MAX_NS    10000
`define T_RP_MIN_NS     120
`define T_CAS_MIN_NS    135
`define T_CP_MIN_NS     80
`define T_PC_MIN_NS     206
`define T_RCD_MIN_NS    25
`define T_RSH_MIN_NS    135
`define T_RWD_MIN_NS    100
`define T_CWD_MIN_NS    50
`define T_ASR_MIN_NS    0
`define CYC_MIN(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_MAX(ns) (((ns) * 64'd1000) / `CLK_PERIOD_PS)
`endif

// >>> dram_ctrl_pkg.sv
// Types for the multiplexed-address DRAM controller
package dram_ctrl_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ROW, ST_RCD, ST_CAS, ST_RMW, ST_CPRE, ST_HOLD, ST_PRE
   } state_t;
   typedef struct packed {
      logic       write;
      logic       rmw;
      logic [7:0] row;
      logic [7:0] col;
      logic       wdata;
      logic [1:0] sel;
   } req_t;
   typedef struct packed {
      logic       ras_n;
      logic [3:0] cas_n;
      logic       we_n;
      logic [7:0] addr;
      logic       din;
   } pins_t;
endpackage : dram_ctrl_pkg

// >>> dram_ctrl.sv
// Host-side controller: refresh, page mode and strobe timing for a 64K x 1 DRAM bank
// Function
// RQ1: Whole array refreshed within every 4 ms
// RQ2: Visit all 256 rows each refresh period
// RQ3: Column strobe held high during refresh
// RQ4: Device output floats without column strobe
// RQ5: Page mode: row open, columns strobed
// RQ6: Common row strobe, decoded column strobes
// RQ7: Page column cycles spaced at least 206 ns
// RQ8: Row strobe low 200 ns to 10 us; a column accepted close to C_RMAX can hold it low past 10 us
// RQ9: Row strobe precharge at least 120 ns
// RQ10: Column strobe low 135 ns to 10 us
// RQ11: Column strobe high 80 ns in page
// RQ12: Column strobe falls 25 ns after row
// RQ13: Column strobe high before row strobe falls
// RQ14: Row rises 135 ns after last column fall
// RQ15: Modify-write: write enable delayed after strobes
// RQ16: Eight-bit counter, evenly spaced row-only refresh
// RQ17: Row address then column address, same lines
// RQ18: Write enable high reads, low writes
// RQ19: Early write leaves device output floating
// RQ20: Read data valid while column strobe low
`timescale 1ns/1ps
`include "dram_ctrl_consts.svh"
module dram_ctrl #(
   parameter int REF_INTERVAL = int'(`CYC_MAX(`REF_PERIOD_NS) / `ROW_COUNT) - 64,
   parameter int ACCESS_CYC   = `CYC_MIN(`T_CAS_MIN_NS) - 1
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire dram_ctrl_pkg::req_t  req,
   input  wire logic                 req_last,
   output logic                      rsp_valid,
   output logic                      rsp_data,
   output logic                      busy,
   output dram_ctrl_pkg::pins_t      pins,
   input  wire logic                 dout
);
   localparam logic [7:0] C_RAS  = 8'(`CYC_MIN(`T_RAS_MIN_NS));
   localparam logic [7:0] C_RP   = 8'(`CYC_MIN(`T_RP_MIN_NS));
   localparam logic [7:0] C_CAS  = 8'(`CYC_MIN(`T_CAS_MIN_NS));
   localparam logic [7:0] C_CP   = 8'(`CYC_MIN(`T_CP_MIN_NS));
   localparam logic [7:0] C_PC   = 8'(`CYC_MIN(`T_PC_MIN_NS));
   localparam logic [7:0] C_RCD  = 8'(`CYC_MIN(`T_RCD_MIN_NS));
   localparam logic [7:0] C_RSH  = 8'(`CYC_MIN(`T_RSH_MIN_NS));
   localparam logic [7:0] C_RWD  = 8'(`CYC_MIN(`T_RWD_MIN_NS));
   localparam logic [7:0] C_CWD  = 8'(`CYC_MIN(`T_CWD_MIN_NS));
   localparam logic [11:0] C_RMAX = 12'(`CYC_MAX(`T_RAS_MAX_NS) - 16);
   localparam logic [7:0] C_ACC  = 8'(ACCESS_CYC);
   localparam logic [19:0] C_REF = 20'(REF_INTERVAL);

   typedef struct packed {
      dram_ctrl_pkg::state_t st;
      dram_ctrl_pkg::pins_t  pins;
      dram_ctrl_pkg::req_t   cur;
      logic                  refresh;
      logic                  last;
      logic [7:0]            tmr;
      logic [7:0]            pc_tmr;
      logic [11:0]           ras_tmr;
      logic [7:0]            ref_row;
      logic [19:0]           ref_tmr;
      logic                  ref_pend;
      logic                  rsp_valid;
      logic                  rsp_data;
   } state_s_t;

   state_s_t s_q;
   state_s_t s_d;

   // Accept a row in idle with no refresh pending, or a new column while row is open and timers elapsed
   assign req_ready = (s_q.st == dram_ctrl_pkg::ST_IDLE && !s_q.ref_pend
                       && s_q.tmr == 8'h00)
                      || (s_q.st == dram_ctrl_pkg::ST_CPRE && s_q.tmr == 8'h00
                          && s_q.pc_tmr == 8'h00 && !s_q.last);
   assign pins      = s_q.pins;
   assign rsp_valid = s_q.rsp_valid;
   assign rsp_data  = s_q.rsp_data;
   assign busy      = s_q.st != dram_ctrl_pkg::ST_IDLE;

   always_comb begin
      s_d = s_q;
      s_d.rsp_valid = 1'b0;
      if (s_q.tmr != 8'h00) begin
         s_d.tmr = s_q.tmr - 8'h01;
      end
      if (s_q.pc_tmr != 8'h00) begin
         s_d.pc_tmr = s_q.pc_tmr - 8'h01;
      end
      if (!s_q.pins.ras_n) begin
         s_d.ras_tmr = s_q.ras_tmr + 12'h001;
      end
      // Evenly spaced refresh requests
      if (s_q.ref_tmr == 20'h00000) begin // [RQ1] [RQ16]
         s_d.ref_tmr  = C_REF;
         s_d.ref_pend = 1'b1;
      end else begin
         s_d.ref_tmr = s_q.ref_tmr - 20'h00001;
      end
      case (s_q.st)
         dram_ctrl_pkg::ST_IDLE: begin
            // Column strobes all high here, so row fall is safe
            if (s_q.tmr == 8'h00) begin // [RQ9] [RQ13]
               if (s_q.ref_pend) begin
                  s_d.refresh   = 1'b1;
                  s_d.pins.addr = s_q.ref_row; // [RQ2]
                  s_d.st        = dram_ctrl_pkg::ST_ROW;
               end else if (req_valid) begin
                  s_d.refresh   = 1'b0;
                  s_d.cur       = req;
                  s_d.last      = req_last;
                  s_d.pins.addr = req.row; // [RQ17]
                  s_d.st        = dram_ctrl_pkg::ST_ROW;
               end
            end
         end
         dram_ctrl_pkg::ST_ROW: begin
            s_d.pins.ras_n = 1'b0; // [RQ6]
            s_d.ras_tmr    = 12'h000;
            if (s_q.refresh) begin
               s_d.tmr = C_RAS - 8'h01; // [RQ8]
               s_d.st  = dram_ctrl_pkg::ST_HOLD; // [RQ3]
            end else begin
               s_d.tmr = C_RCD - 8'h01; // [RQ12]
               s_d.st  = dram_ctrl_pkg::ST_RCD;
            end
         end
         dram_ctrl_pkg::ST_RCD: begin
            if (s_q.tmr == 8'h00) begin
               s_d.pins.addr = s_q.cur.col; // [RQ17]
               s_d.pins.din  = s_q.cur.wdata;
               // Early write: enable low before column strobe
               s_d.pins.we_n = !(s_q.cur.write && !s_q.cur.rmw); // [RQ18] [RQ19]
               s_d.st        = dram_ctrl_pkg::ST_CAS;
            end
         end
         dram_ctrl_pkg::ST_CAS: begin
            s_d.pins.cas_n               = 4'hf;
            s_d.pins.cas_n[s_q.cur.sel]  = 1'b0; // [RQ6] [RQ5]
            s_d.tmr                      = C_CAS - 8'h01; // [RQ10]
            s_d.pc_tmr                   = C_PC - 8'h01; // [RQ7]
            s_d.st = s_q.cur.rmw ? dram_ctrl_pkg::ST_RMW : dram_ctrl_pkg::ST_CPRE;
         end
         dram_ctrl_pkg::ST_RMW: begin
            if (s_q.tmr == C_CAS - C_ACC) begin
               s_d.rsp_valid = 1'b1;
               s_d.rsp_data  = dout; // [RQ20]
            end
            // Delayed write once both strobe delays elapsed and data was read
            if (s_q.ras_tmr >= 12'(C_RWD) && s_q.tmr <= C_CAS - C_CWD
                && s_q.tmr < C_CAS - C_ACC) begin // [RQ15]
               s_d.pins.we_n = 1'b0;
               s_d.tmr       = C_CAS - 8'h01;
               s_d.st        = dram_ctrl_pkg::ST_CPRE;
            end
         end
         dram_ctrl_pkg::ST_CPRE: begin
            if (!(&s_q.pins.cas_n)) begin
               // Sample read data before raising the column strobe
               if (s_q.tmr == C_CAS - C_ACC && s_q.pins.we_n && !s_q.cur.rmw) begin
                  s_d.rsp_valid = 1'b1;
                  s_d.rsp_data  = dout; // [RQ20]
               end
               if (s_q.tmr == 8'h00) begin
                  s_d.pins.cas_n = 4'hf;
                  s_d.pins.we_n  = 1'b1;
                  s_d.tmr        = C_CP - 8'h01; // [RQ11]
                  if (s_q.last || s_q.ras_tmr >= C_RMAX) begin
                     s_d.tmr = (C_RSH > C_CAS) ? C_RSH - C_CAS : 8'h00; // [RQ14]
                     s_d.st  = dram_ctrl_pkg::ST_HOLD;
                  end
               end
            end else if (s_q.tmr == 8'h00 && s_q.pc_tmr == 8'h00 && req_valid) begin
               s_d.cur       = req;
               s_d.cur.row   = s_q.cur.row;
               s_d.last      = req_last;
               s_d.pins.addr = req.col;
               s_d.pins.din  = req.wdata;
               s_d.pins.we_n = !(req.write && !req.rmw);
               s_d.st        = dram_ctrl_pkg::ST_CAS; // [RQ5]
            end else if (s_q.ras_tmr >= C_RMAX) begin
               s_d.tmr = 8'h00;
               s_d.st  = dram_ctrl_pkg::ST_HOLD; // [RQ8]
            end
         end
         dram_ctrl_pkg::ST_HOLD: begin
            if (s_q.tmr == 8'h00 && s_q.ras_tmr >= 12'(C_RAS)) begin // [RQ8]
               s_d.pins.ras_n = 1'b1;
               s_d.pins.cas_n = 4'hf;
               s_d.tmr        = C_RP - 8'h01; // [RQ9]
               if (s_q.refresh) begin
                  s_d.ref_row  = s_q.ref_row + 8'h01; // [RQ2] [RQ16]
                  s_d.ref_pend = (s_q.ref_tmr == 20'h00000);
               end
               s_d.st = dram_ctrl_pkg::ST_PRE;
            end
         end
         dram_ctrl_pkg::ST_PRE: begin
            s_d.st = dram_ctrl_pkg::ST_IDLE;
         end
         default: begin
            s_d.st = dram_ctrl_pkg::ST_IDLE;
         end
      endcase
      // Refresh request set wins over the clear
      if (s_q.ref_tmr == 20'h00000) begin
         s_d.ref_pend = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q            <= '0;
         s_q.st         <= dram_ctrl_pkg::ST_IDLE;
         s_q.pins.ras_n <= 1'b1;
         s_q.pins.cas_n <= 4'hf;
         s_q.pins.we_n  <= 1'b1;
         s_q.ref_tmr    <= 20'h00000;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : dram_ctrl

// >>> dram_ctrl_assertions.sv
// Strobe timing and one-hot decode checks on the DRAM controller pins
`timescale 1ns/1ps
module dram_ctrl_assertions (
   input wire logic                 sys_clk,
   input wire logic                 rst,
   input wire logic                 req_valid,
   input wire logic                 req_ready,
   input wire dram_ctrl_pkg::req_t  req,
   input wire logic                 req_last,
   input wire logic                 rsp_valid,
   input wire logic                 rsp_data,
   input wire logic                 busy,
   input wire dram_ctrl_pkg::pins_t pins,
   input wire logic                 dout
);
   logic       ca;
   logic [7:0] rl_q, rh_q, cl_q, cf_q;
   function automatic logic [7:0] up(input logic [7:0] v);
      return v + {7'h00, v != 8'hff};
   endfunction : up
   assign ca = &pins.cas_n;
   always_ff @(posedge sys_clk) rl_q <= (rst || pins.ras_n) ? 8'h00 : up(rl_q);
   always_ff @(posedge sys_clk) rh_q <= rst ? 8'hff : (pins.ras_n ? up(rh_q) : 8'h00);
   always_ff @(posedge sys_clk) cl_q <= (rst || ca) ? 8'h00 : up(cl_q);
   always_ff @(posedge sys_clk) cf_q <= rst ? 8'hff : ($fell(ca) ? 8'h01 : up(cf_q));
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_cas_fall;
      $fell(ca);
   endsequence
   a_ras_low_min: assert property ($rose(pins.ras_n) |-> rl_q >= 8'h32)
      else $error("row low too short");
   a_ras_pre_min: assert property ($fell(pins.ras_n) |-> rh_q >= 8'h1e)
      else $error("row precharge short");
   a_cas_low_min: assert property ($rose(ca) |-> cl_q >= 8'h22)
      else $error("column low too short");
   a_cas_delay: assert property (s_cas_fall |-> !pins.ras_n && rl_q >= 8'h07)
      else $error("column fell too early");
   a_cas_before_ras: assert property ($fell(pins.ras_n) |-> ca)
      else $error("column low at row fall");
   a_ras_hold: assert property ($rose(pins.ras_n) |-> cf_q >= 8'h22)
      else $error("row rose too soon");
   a_page_spacing: assert property (s_cas_fall |-> cf_q >= 8'h34)
      else $error("page cycle too short");
   a_one_device: assert property ($onehot0(~pins.cas_n))
      else $error("two column strobes low");
endmodule : dram_ctrl_assertions
bind dram_ctrl dram_ctrl_assertions u_dram_ctrl_assertions (.sys_clk(sys_clk), .rst(rst),
   .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_last(req_last),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .pins(pins), .dout(dout));

// >>> dram_model.sv
// Behavioural four-device 64K x 1 DRAM bank
`timescale 1ns/1ps
module dram_model #(
   parameter int ACC = 30
) (
   input  wire logic                 sys_clk,
   input  wire dram_ctrl_pkg::pins_t pins,
   output logic                      dout
);
   logic         mem [4][65536];
   logic [255:0] seen = '0;
   logic [7:0]   row, col, lo;
   logic [1:0]   dv, dev;
   logic         ras_q = 1'b1, cas_q = 1'b1, we_q = 1'b1, rd = 1'b0, hit, rb, tog = 1'b0;
   assign dev = pins.cas_n[0] ? (pins.cas_n[1] ? (pins.cas_n[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
   always @(posedge sys_clk) begin
      {ras_q, cas_q, we_q, tog} <= {pins.ras_n, &pins.cas_n, pins.we_n, ~tog};
      lo <= (&pins.cas_n) ? 8'h00 : lo + 8'h01;
      if (ras_q && !pins.ras_n) {row, hit} <= {pins.addr, 1'b0};
      if (!ras_q && pins.ras_n && !hit) seen[row] <= 1'b1;
      if (cas_q && !(&pins.cas_n)) begin
         {col, hit, rd, dv} <= {pins.addr, 1'b1, pins.we_n, dev};
         rb <= mem[dev][{row, pins.addr}];
         if (!pins.we_n) mem[dev][{row, pins.addr}] <= pins.din;
      end
      if (!cas_q && !(&pins.cas_n) && we_q && !pins.we_n) mem[dv][{row, col}] <= pins.din;
   end
   // Undriven output toggles so a stale value is never mistaken for data
   assign dout = (rd && !(&pins.cas_n) && lo >= ACC) ? rb : tog;
endmodule : dram_model

// >>> dram_ctrl_bench.sv
// Self-checking bench for the DRAM controller
`timescale 1ns/1ps
module dram_ctrl_bench;
   localparam int RI = 200;
   logic                 sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_last = 1'b0;
   logic                 req_ready, rsp_valid, rsp_data, busy, dout, q;
   dram_ctrl_pkg::req_t  req = '0;
   dram_ctrl_pkg::pins_t pins;
   int                   fails = 0, tests_run = 0;
   always #2 sys_clk = ~sys_clk;
   dram_ctrl #(.REF_INTERVAL(RI)) u_dram_ctrl (.sys_clk(sys_clk), .rst(rst),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_last(req_last),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .pins(pins), .dout(dout));
   dram_model u_dram_model (.sys_clk(sys_clk), .pins(pins), .dout(dout));
   task automatic chk(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, m, input logic [7:0] c, input logic d,
                      input logic [1:0] s, input logic l);
      int n;
      @(posedge sys_clk) #1;
      req_valid = 1'b1;
      req = '{w, m, 8'h5a, c, d, s};
      req_last = l;
      for (n = 0; n < 4000 && req_ready !== 1'b1; n++) @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
      req_valid = 1'b0;
      for (n = 0; n < 200 && !w && rsp_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      if (!w) chk(rsp_valid, 1'b1);
      q = rsp_data;
   endtask : acc
   task automatic t_page;
      acc(1'b1, 1'b0, 8'h00, 1'b1, 2'h0, 1'b0);
      acc(1'b1, 1'b0, 8'hff, 1'b1, 2'h3, 1'b0);
      acc(1'b1, 1'b0, 8'h00, 1'b0, 2'h1, 1'b1);
      acc(1'b0, 1'b0, 8'h00, 1'b0, 2'h0, 1'b0);
      chk(q, 1'b1);
      acc(1'b0, 1'b0, 8'hff, 1'b0, 2'h3, 1'b0);
      chk(q, 1'b1);
      acc(1'b0, 1'b0, 8'h00, 1'b0, 2'h1, 1'b1);
      chk(q, 1'b0);
      $display("page test done");
   endtask : t_page
   task automatic t_rmw;
      acc(1'b0, 1'b1, 8'h00, 1'b0, 2'h0, 1'b1);
      chk(q, 1'b1);
      acc(1'b0, 1'b0, 8'h00, 1'b1, 2'h0, 1'b1);
      chk(q, 1'b0);
      $display("modify-write test done");
   endtask : t_rmw
   task automatic t_refresh;
      repeat (256 * RI + 1000) @(posedge sys_clk);
      #1;
      chk(&u_dram_model.seen, 1'b1);
      $display("refresh test done");
   endtask : t_refresh
   task automatic test_done;
      $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      @(posedge sys_clk) #1;
      chk(busy, 1'b0);
      @(posedge sys_clk) #1;
      chk(busy, 1'b1);
      t_page;
      t_rmw;
      t_refresh;
      test_done;
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      test_done;
   end
endmodule : dram_ctrl_bench
